// [rtl/scp_pkg.sv]
package scp_pkg;
    localparam int ADDR_W = 13;
    localparam int BYTE_W = 8;
    localparam int NREG = 91;
    localparam int FIFO_W = ADDR_W + BYTE_W;
    localparam int FIFO_DEPTH = 4;
    localparam logic [12:0] ADDR_CFG = 13'h0000;
    localparam logic [12:0] ADDR_UPD = 13'h005A;
    localparam logic [12:0] ADDR_ONE = 13'h0001;
    localparam int CFG_BIDIR = 7;
    localparam int CFG_LSB = 6;
    localparam int CFG_SRST = 5;
    localparam int UPD_BIT = 0;
    localparam int INS_DIR = 15;
    localparam int INS_LEN_HI = 14;
    localparam int INS_LEN_LO = 13;
    localparam int INS_ADDR_HI = 12;
    localparam logic [7:0] CFG_RESET = 8'h10;
    localparam logic [7:0] REG_DEFAULT = 8'h00;
    localparam logic [7:0] UPD_MASK = 8'hFE;
    localparam logic [3:0] INS_LAST = 4'hF;
    localparam logic [3:0] BYTE_LAST = 4'h7;
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam logic [3:0] BIT_STEP = 4'h1;
    localparam logic [1:0] LEN_STREAM = 2'h3;
    localparam logic [1:0] LEN_ONE = 2'h0;
    localparam logic [1:0] LEN_STEP = 2'h1;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_INSTR = 2'b01,
        ST_DATA  = 2'b10,
        ST_DONE  = 2'b11
    } scp_state_type;
endpackage

// [rtl/scp_top.sv]
`timescale 1ns/100ps

// ****************************************************************
// write-path fifo
// ****************************************************************
module scp_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 4
) (
    input  wire logic         clk,       // core clock
    input  wire logic         rst_b,     // async reset
    input  wire logic         in_valid,  // push request
    output logic              in_ready,  // room available
    input  wire logic [W-1:0] in_data,   // push word
    output logic              out_valid, // word available
    input  wire logic         out_ready, // drain accepts
    output logic      [W-1:0] out_data   // head word
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] wp_d;
    logic [AW-1:0] rp_q;
    logic [AW-1:0] rp_d;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    logic push;
    logic pop;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rp_q];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb begin
        wp_d = push ? wp_q + AW'(1) : wp_q;
        rp_d = pop ? rp_q + AW'(1) : rp_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    // storage needs no reset: count guards every read
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end
endmodule

// ****************************************************************
// serial control port slave
// ****************************************************************
module scp_top (
    input  wire logic                   clk,             // core clock 125 MHz
    input  wire logic                   rst_b,           // async reset, low
    input  wire logic                   sclk_pin,        // host shift clock
    input  wire logic                   select_n,        // host select, low
    input  wire logic                   sdio_in,         // data pin level
    output logic                        sdio_out,        // data pin drive
    output logic                        sdio_oe_n,       // data pin enable, low
    output logic                        serial_out_pin,  // readback pin
    output logic                        serial_out_oe_n, // readback enable, low
    input  wire logic                   sync_req,        // sync event pin
    output logic [scp_pkg::NREG*8-1:0]  live_regs,       // live registers
    output logic [scp_pkg::NREG*8-1:0]  synced_regs      // sync-gated copy
);
    logic [2:0] sclk_s_q;
    logic [2:0] sel_s_q;
    logic [1:0] sdi_s_q;
    logic [2:0] sync_s_q;
    scp_pkg::scp_state_type state_q;
    scp_pkg::scp_state_type state_d;
    logic [3:0] bit_q, bit_d;
    logic [15:0] inst_q, inst_d;
    logic [7:0] rx_q, rx_d;
    logic [7:0] tx_q, tx_d;
    logic [12:0] addr_q, addr_d;
    logic [1:0] left_q, left_d;
    logic rd_q, rd_d;
    logic stream_q, stream_d;
    logic out_q, out_d;
    logic sdio_oe_n_q, sdio_oe_n_d;
    logic so_oe_n_q, so_oe_n_d;
    logic pend_q, pend_d;
    logic [scp_pkg::FIFO_W-1:0] pdat_q, pdat_d;
    logic [7:0] cfg_q, cfg_d;
    logic [7:0] buf_q [scp_pkg::NREG];
    logic [7:0] buf_d [scp_pkg::NREG];
    logic [7:0] live_q [scp_pkg::NREG];
    logic [7:0] live_d [scp_pkg::NREG];
    logic [7:0] sync_q [scp_pkg::NREG];
    logic [7:0] sync_d [scp_pkg::NREG];
    logic commit_q, commit_d;
    logic rise, fall, sel_rise, sync_edge, lsb, drive;
    logic [15:0] inst_n;
    logic [7:0] rx_n;
    logic [12:0] addr_n;
    logic f_ready, f_valid;
    logic [scp_pkg::FIFO_W-1:0] f_data;
    logic [12:0] wa;
    logic [7:0] wd;

    // out-of-range addresses read zero; 0x00 reads the live config
    function automatic logic [7:0] rd_byte(input logic [12:0] a);
        logic [7:0] r;
        r = 8'h00;
        if (a == scp_pkg::ADDR_CFG) begin
            r = cfg_q;
        end else if (a <= scp_pkg::ADDR_UPD) begin
            r = buf_q[a[6:0]];
        end
        return r;
    endfunction

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_s_q <= 3'h0;
            sel_s_q <= 3'h7;
            sdi_s_q <= 2'h0;
            sync_s_q <= 3'h0;
        end else begin
            sclk_s_q <= {sclk_s_q[1:0], sclk_pin};
            sel_s_q <= {sel_s_q[1:0], select_n};
            sdi_s_q <= {sdi_s_q[0], sdio_in};
            sync_s_q <= {sync_s_q[1:0], sync_req};
        end
    end

    assign rise = sclk_s_q[1] & ~sclk_s_q[2] & ~sel_s_q[1];
    assign fall = ~sclk_s_q[1] & sclk_s_q[2] & ~sel_s_q[1];
    assign sel_rise = sel_s_q[1] & ~sel_s_q[2];
    assign sync_edge = sync_s_q[1] & ~sync_s_q[2];
    assign lsb = cfg_q[scp_pkg::CFG_LSB];

    // ****************************************************************
    // serial state machine
    // ****************************************************************
    always_comb begin
        state_d = state_q;
        bit_d = bit_q;
        inst_d = inst_q;
        rx_d = rx_q;
        tx_d = tx_q;
        addr_d = addr_q;
        left_d = left_q;
        rd_d = rd_q;
        stream_d = stream_q;
        out_d = out_q;
        pend_d = pend_q & ~f_ready;
        pdat_d = pdat_q;
        // always 16-bit instructions, shift order per config
        inst_n = lsb ? {sdi_s_q[1], inst_q[15:1]} : {inst_q[14:0], sdi_s_q[1]};
        rx_n = lsb ? {sdi_s_q[1], rx_q[7:1]} : {rx_q[6:0], sdi_s_q[1]};
        addr_n = lsb ? addr_q + scp_pkg::ADDR_ONE : addr_q - scp_pkg::ADDR_ONE;
        case (state_q)
            scp_pkg::ST_IDLE: begin
                if (!sel_s_q[1]) begin
                    state_d = scp_pkg::ST_INSTR;
                    bit_d = scp_pkg::BIT_FIRST;
                end
            end
            scp_pkg::ST_INSTR: begin
                if (rise) begin
                    inst_d = inst_n;
                    bit_d = bit_q + scp_pkg::BIT_STEP;
                    if (bit_q == scp_pkg::INS_LAST) begin
                        state_d = scp_pkg::ST_DATA;
                        bit_d = scp_pkg::BIT_FIRST;
                        rd_d = inst_n[scp_pkg::INS_DIR];
                        addr_d = inst_n[scp_pkg::INS_ADDR_HI:0];
                        left_d = inst_n[scp_pkg::INS_LEN_HI:scp_pkg::INS_LEN_LO];
                        stream_d = (inst_n[scp_pkg::INS_LEN_HI:scp_pkg::INS_LEN_LO]
                                    == scp_pkg::LEN_STREAM);
                        tx_d = rd_byte(inst_n[scp_pkg::INS_ADDR_HI:0]);
                    end
                end
            end
            scp_pkg::ST_DATA: begin
                if (rise) begin
                    rx_d = rx_n;
                    bit_d = bit_q + scp_pkg::BIT_STEP;
                    if (bit_q == scp_pkg::BYTE_LAST) begin
                        bit_d = scp_pkg::BIT_FIRST;
                        if (!rd_q) begin
                            pend_d = 1'b1;
                            pdat_d = {addr_q, rx_n};
                        end
                        addr_d = addr_n;
                        tx_d = rd_byte(addr_n);
                        if (!stream_q && left_q == scp_pkg::LEN_ONE) begin
                            state_d = scp_pkg::ST_DONE;
                        end else if (!stream_q) begin
                            left_d = left_q - scp_pkg::LEN_STEP;
                        end
                    end
                end
                if (fall && rd_q) begin
                    out_d = lsb ? tx_q[0] : tx_q[7];
                    tx_d = lsb ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
                end
            end
            scp_pkg::ST_DONE: begin
            end
            default: begin
                state_d = scp_pkg::ST_IDLE;
            end
        endcase
        // byte-boundary release pauses a counted transfer; anything else abandons
        if (sel_rise) begin
            // a stream has no pause: a boundary rise ends it
            if (state_q == scp_pkg::ST_DONE || bit_q != scp_pkg::BIT_FIRST
                || (state_q == scp_pkg::ST_DATA && stream_q)) begin
                state_d = scp_pkg::ST_IDLE;
                bit_d = scp_pkg::BIT_FIRST;
            end
        end
        drive = ~sel_s_q[1] & rd_q & (state_q == scp_pkg::ST_DATA
                                      || state_q == scp_pkg::ST_DONE);
        sdio_oe_n_d = ~(drive & cfg_q[scp_pkg::CFG_BIDIR]);
        so_oe_n_d = ~(drive & ~cfg_q[scp_pkg::CFG_BIDIR]);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= scp_pkg::ST_IDLE;
            bit_q <= scp_pkg::BIT_FIRST;
            inst_q <= 16'h0000;
            rx_q <= 8'h00;
            tx_q <= 8'h00;
            addr_q <= 13'h0000;
            left_q <= 2'h0;
            rd_q <= 1'b0;
            stream_q <= 1'b0;
            out_q <= 1'b0;
            sdio_oe_n_q <= 1'b1;
            so_oe_n_q <= 1'b1;
            pend_q <= 1'b0;
            pdat_q <= '0;
        end else begin
            state_q <= state_d;
            bit_q <= bit_d;
            inst_q <= inst_d;
            rx_q <= rx_d;
            tx_q <= tx_d;
            addr_q <= addr_d;
            left_q <= left_d;
            rd_q <= rd_d;
            stream_q <= stream_d;
            out_q <= out_d;
            sdio_oe_n_q <= sdio_oe_n_d;
            so_oe_n_q <= so_oe_n_d;
            pend_q <= pend_d;
            pdat_q <= pdat_d;
        end
    end

    // a full fifo holds the byte in pdat_q, with pend_q set, until room appears
    scp_fifo #(.W(scp_pkg::FIFO_W), .DEPTH(scp_pkg::FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_valid  (pend_q),
        .in_ready  (f_ready),
        .in_data   (pdat_q),
        .out_valid (f_valid),
        .out_ready (~commit_q),
        .out_data  (f_data)
    );

    // ****************************************************************
    // register buffer, live and synced copies
    // ****************************************************************
    always_comb begin
        cfg_d = cfg_q;
        buf_d = buf_q;
        live_d = live_q;
        sync_d = sync_q;
        commit_d = 1'b0;
        wa = f_data[scp_pkg::FIFO_W-1:scp_pkg::BYTE_W];
        wd = f_data[scp_pkg::BYTE_W-1:0];
        // drain pauses the cycle after a commit so the copy settles
        if (f_valid && !commit_q && wa <= scp_pkg::ADDR_UPD) begin
            if (wa == scp_pkg::ADDR_CFG) begin
                cfg_d = wd;
            end else if (wa == scp_pkg::ADDR_UPD) begin
                buf_d[wa[6:0]] = wd & scp_pkg::UPD_MASK;
                if (wd[scp_pkg::UPD_BIT]) begin
                    live_d = buf_q;
                    commit_d = 1'b1;
                end
            end else begin
                buf_d[wa[6:0]] = wd;
            end
        end
        if (cfg_q[scp_pkg::CFG_SRST]) begin
            for (int i = 0; i < scp_pkg::NREG; i++) begin
                buf_d[i] = scp_pkg::REG_DEFAULT;
                live_d[i] = scp_pkg::REG_DEFAULT;
            end
        end
        if (sync_edge) begin
            sync_d = live_q;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q <= scp_pkg::CFG_RESET;
            commit_q <= 1'b0;
            for (int i = 0; i < scp_pkg::NREG; i++) begin
                buf_q[i] <= scp_pkg::REG_DEFAULT;
                live_q[i] <= scp_pkg::REG_DEFAULT;
                sync_q[i] <= scp_pkg::REG_DEFAULT;
            end
        end else begin
            cfg_q <= cfg_d;
            commit_q <= commit_d;
            buf_q <= buf_d;
            live_q <= live_d;
            sync_q <= sync_d;
        end
    end

    assign sdio_out = out_q;
    assign serial_out_pin = out_q;
    assign sdio_oe_n = sdio_oe_n_q;
    assign serial_out_oe_n = so_oe_n_q;

    genvar g;
    generate
        for (g = 0; g < scp_pkg::NREG; g++) begin : g_out
            assign live_regs[g*8 +: 8] = live_q[g];
            assign synced_regs[g*8 +: 8] = sync_q[g];
        end
    endgenerate
endmodule

// [dv/scp_top_sva.sv]
`timescale 1ns/100ps
// ****************************************************************
// port checker
// ****************************************************************
module scp_sva (
    input wire logic                       clk,             // core clock
    input wire logic                       rst_b,           // async reset, low
    input wire logic                       sclk_pin,        // host shift clock
    input wire logic                       select_n,        // host select, low
    input wire logic                       sdio_in,         // data pin level
    input wire logic                       sdio_out,        // data pin drive
    input wire logic                       sdio_oe_n,       // data pin enable, low
    input wire logic                       serial_out_pin,  // readback pin
    input wire logic                       serial_out_oe_n, // readback enable, low
    input wire logic                       sync_req,        // sync event pin
    input wire logic [scp_pkg::NREG*8-1:0] live_regs,       // live registers
    input wire logic [scp_pkg::NREG*8-1:0] synced_regs      // sync-gated copy
);
    logic       sclk_q;
    logic       sync_q;
    logic [3:0] fall_q;
    logic [3:0] rise_q;
    logic [3:0] scnt_q;
    logic [3:0] fall_d;
    logic [3:0] rise_d;
    logic [3:0] scnt_d;

    // raw samples, so the counts run one or two clk ahead of the synced view
    always_comb begin
        fall_d = (sclk_q && !sclk_pin) ? 4'h0 : fall_q + {3'h0, fall_q != 4'hF};
        rise_d = (!sclk_q && sclk_pin) ? 4'h0 : rise_q + {3'h0, rise_q != 4'hF};
        scnt_d = (!sync_q && sync_req) ? 4'h0 : scnt_q + {3'h0, scnt_q != 4'hF};
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_q <= 1'b0;
            sync_q <= 1'b0;
            fall_q <= 4'hF;
            rise_q <= 4'hF;
            scnt_q <= 4'hF;
        end else begin
            sclk_q <= sclk_pin;
            sync_q <= sync_req;
            fall_q <= fall_d;
            rise_q <= rise_d;
            scnt_q <= scnt_d;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    release_idle_a: assert property (select_n [*6] |-> serial_out_oe_n && sdio_oe_n)
        else $error("pin driven while deselected");
    one_pin_a: assert property (sdio_oe_n || serial_out_oe_n)
        else $error("both readback pins driven");
    oe_cause_a: assert property (($fell(serial_out_oe_n) || $fell(sdio_oe_n)) |->
        (!$past(select_n, 4) && rise_q <= 4'd7)) else $error("readback enable out of place");
    so_edge_a: assert property (!serial_out_oe_n && $past(!serial_out_oe_n) &&
        $changed(serial_out_pin) |-> fall_q <= 4'd7) else $error("readback pin off fall edge");
    sdio_edge_a: assert property (!sdio_oe_n && $past(!sdio_oe_n) &&
        $changed(sdio_out) |-> fall_q <= 4'd7) else $error("data pin off fall edge");
    sync_gate_a: assert property ($changed(synced_regs) |-> scnt_q <= 4'd6)
        else $error("synced set moved without sync");
    sync_copy_a: assert property ($rose(sync_req) |-> ##[3:8] (synced_regs == live_regs))
        else $error("sync did not copy live set");
    live_atomic_a: assert property ($changed(live_regs) |=> $stable(live_regs) [*4])
        else $error("live set changed piecewise");
endmodule

bind scp_top scp_sva i_sva (.clk, .rst_b, .sclk_pin, .select_n, .sdio_in, .sdio_out,
    .sdio_oe_n, .serial_out_pin, .serial_out_oe_n, .sync_req, .live_regs, .synced_regs);

// [dv/scp_host.sv]
`timescale 1ns/100ps
// ****************************************************************
// host model on the serial link
// ****************************************************************
module scp_host (
    input  wire logic clk,      // core clock, paces the shift clock
    input  wire logic so_pin,   // readback pin
    input  wire logic sdio_pin, // resolved data pin
    output logic      sclk,     // shift clock, still outside frames
    output logic      sel_n,    // select, low
    output logic      drv       // host value on data pin
);
    logic lsb;   // bit order in use
    logic bidir; // readback taken from data pin

    initial begin
        sclk = 1'b0;
        sel_n = 1'b1;
        drv = 1'b0;
        lsb = 1'b0;
        bidir = 1'b0;
    end

    task half;
        repeat (8) @(negedge clk);
    endtask

    // select moves only between whole bytes, except for a deliberate abort
    task sel(input logic v);
        half;
        sel_n = v;
        half;
    endtask

    task automatic xbits(input logic [7:0] d, input int n, input logic rel,
                         output logic [7:0] r);
        int i;
        r = 8'h00;
        for (i = 0; i < n; i++) begin
            // a released line must not keep its last level
            drv = rel ? ~drv : d[lsb ? i : 7 - i];
            half;
            sclk = 1'b1;
            r[lsb ? i : 7 - i] = bidir ? sdio_pin : so_pin;
            half;
            sclk = 1'b0;
        end
    endtask
endmodule

// [dv/serial_control_port_slave_bench.sv]
`timescale 1ns/100ps
// ****************************************************************
// bench top
// ****************************************************************
module serial_control_port_slave_bench;
    logic                       clk;
    logic                       rst_b;
    logic                       sync_req;
    logic                       sdio_out;
    logic                       sdio_oe_n;
    logic                       so_pin;
    logic                       so_oe_n;
    logic                       sclk;
    logic                       sel_n;
    logic                       drv;
    logic [7:0]                 d;
    logic [7:0]                 wb [4];
    logic [7:0]                 rb [4];
    logic [scp_pkg::NREG*8-1:0] live;
    logic [scp_pkg::NREG*8-1:0] synced;
    int                         failures;
    int                         comparisons;
    wire logic                  sdio_line = !sdio_oe_n ? sdio_out : drv;

    always #4 clk = ~clk;

    scp_top i_dut (.clk, .rst_b, .sclk_pin(sclk), .select_n(sel_n), .sdio_in(sdio_line),
        .sdio_out, .sdio_oe_n, .serial_out_pin(so_pin), .serial_out_oe_n(so_oe_n),
        .sync_req, .live_regs(live), .synced_regs(synced));

    scp_host i_host (.clk, .so_pin, .sdio_pin(sdio_line), .sclk, .sel_n, .drv);

    task chk8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // upper six address bits always zero from this side
    task automatic access(input logic rd, input logic [1:0] len, input logic [12:0] a,
                          input int n, input logic pz);
        logic [15:0] ins;
        int          k;
        ins = {rd, len, a};
        i_host.sel(1'b0);
        i_host.xbits(i_host.lsb ? ins[7:0] : ins[15:8], 8, 1'b0, d);
        i_host.xbits(i_host.lsb ? ins[15:8] : ins[7:0], 8, 1'b0, d);
        for (k = 0; k < n; k++) begin
            if (pz && k > 0) begin
                i_host.sel(1'b1);
                i_host.sel(1'b0);
            end
            i_host.xbits(wb[k], 8, rd, d);
            rb[k] = d;
        end
        i_host.sel(1'b1);
    endtask

    task automatic rdchk(input logic [1:0] len, input logic [12:0] a, input int n);
        int k;
        access(1'b1, len, a, n, 1'b0);
        for (k = 0; k < n; k++)
            chk8(rb[k], wb[k]);
    endtask

    task give_verdict;
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #400000;
        failures++;
        give_verdict;
    end

    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        sync_req = 1'b0;
        failures = 0;
        comparisons = 0;
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        wb = '{scp_pkg::CFG_RESET, 8'h00, 8'h00, 8'h00};
        rdchk(2'h0, 13'h0000, 1);
        wb = '{8'hA5, 8'h3C, 8'h00, 8'h00};
        access(1'b0, 2'h1, 13'h0005, 2, 1'b0);
        chk8(live[40 +: 8], 8'h00);
        rdchk(2'h1, 13'h0005, 2);
        wb[0] = 8'h3C;
        rdchk(2'h0, 13'h0004, 1);
        wb[0] = 8'h01;
        access(1'b0, 2'h0, 13'h005A, 1, 1'b0);
        chk8(live[40 +: 8], 8'hA5);
        chk8(live[32 +: 8], 8'h3C);
        wb[0] = 8'h00;
        rdchk(2'h0, 13'h005A, 1);
        chk8(synced[40 +: 8], 8'h00);
        @(negedge clk) sync_req = 1'b1;
        repeat (6) @(negedge clk);
        sync_req = 1'b0;
        repeat (4) @(negedge clk);
        chk8(synced[40 +: 8], 8'hA5);
        wb = '{8'h11, 8'h22, 8'h33, 8'h00};
        access(1'b0, 2'h2, 13'h000C, 3, 1'b1);
        rdchk(2'h2, 13'h000C, 3);
        // abandon a data byte half way; nothing may land
        i_host.sel(1'b0);
        i_host.xbits(8'h00, 8, 1'b0, d);
        i_host.xbits(8'h10, 8, 1'b0, d);
        i_host.xbits(8'hFF, 4, 1'b0, d);
        i_host.sel(1'b1);
        wb[0] = 8'h00;
        rdchk(2'h0, 13'h0010, 1);
        wb[0] = 8'h66;
        access(1'b0, 2'h0, 13'h0060, 1, 1'b0);
        wb[0] = 8'h00;
        rdchk(2'h0, 13'h0060, 1);
        wb = '{8'h81, 8'h42, 8'h24, 8'h18};
        access(1'b0, 2'h3, 13'h0023, 4, 1'b0);
        rdchk(2'h3, 13'h0023, 4);
        wb[0] = 8'h80;
        access(1'b0, 2'h0, 13'h0000, 1, 1'b0);
        i_host.bidir = 1'b1;
        wb = '{8'h81, 8'h42, 8'h24, 8'h18};
        rdchk(2'h1, 13'h0023, 2);
        wb[0] = 8'hC0;
        access(1'b0, 2'h0, 13'h0000, 1, 1'b0);
        i_host.lsb = 1'b1;
        rdchk(2'h0, 13'h0000, 1);
        wb = '{8'h12, 8'h34, 8'h00, 8'h00};
        access(1'b0, 2'h1, 13'h0030, 2, 1'b0);
        rdchk(2'h1, 13'h0030, 2);
        wb[0] = 8'h34;
        rdchk(2'h0, 13'h0031, 1);
        give_verdict;
    end
endmodule
